// ---- src/svm_cfg.svh ----
// Offsets, field positions, reset values and counts for the supply monitor control.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
`ifndef SVM_CFG_SVH
`define SVM_CFG_SVH

// Register byte offsets
`define SVM_OFF_CTRL      4'h0
`define SVM_OFF_FLAG      4'h4
`define SVM_OFF_IE        4'h8

// Control register fields
`define SVM_CTL_SRC       15
`define SVM_CTL_SC_HI     14
`define SVM_CTL_SC_LO     13
`define SVM_CTL_LVL_HI    12
`define SVM_CTL_LVL_LO    8
`define SVM_CTL_ARM_HI    7
`define SVM_CTL_ARM_LO    4
`define SVM_CTL_MD_HI     2
`define SVM_CTL_MD_LO     1
`define SVM_CTL_EN        0

// Status and flag register fields, and interrupt enable bit
`define SVM_FLG_STATUS    8
`define SVM_FLG_IRQ       0
`define SVM_IE_BIT        0

// Reset values
`define SVM_CTRL_RST      16'h0000
`define SVM_IE_RST        1'b0
`define SVM_FLAG_RST      1'b0

// Codes
`define SVM_ARM_KEY       4'ha
`define SVM_MODE_CONT     2'h0
`define SVM_BASE_PERIOD   10'h080

// Stop countdown start after a disable; the stop state lasts one core clock more
`define SVM_STOP_CYC      3'h4

`endif

// ---- src/svm_pkg.sv ----
// Types shared by the supply monitor control files.
// Assumes svm_cfg.svh is on the include path.
package svm_pkg;

    // Detector life cycle
    typedef enum logic [2:0] {
        SVM_ST_OFF  = 3'b001,
        SVM_ST_RUN  = 3'b010,
        SVM_ST_STOP = 3'b100
    } svm_state_t;

    // Stored control fields; the enable bit is derived from the state
    typedef struct packed {
        logic       src;
        logic [1:0] sc;
        logic [4:0] lvl;
        logic [3:0] arm;
        logic [1:0] mode;
    } svm_ctrl_t;

endpackage : svm_pkg

// ---- src/svm_smp_if.sv ----
// Link between the register side and the detection sampler.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps

interface svm_smp_if;
    logic       run;     // Detector running
    logic       init;    // Reinitialise sampling sequence
    logic [1:0] mode;    // Operation mode
    logic [1:0] sc;      // Successive count select
    logic       tick;    // One operating clock period
    logic       low;     // Synchronised comparator result
    logic       event_p; // Detection event

    modport ctl (output run, init, mode, sc, tick, low, input event_p);
    modport smp (input run, init, mode, sc, tick, low, output event_p);
endinterface : svm_smp_if

// ---- src/svm_sampler.sv ----
// Detection sampler: continuous or intermittent, with successive-low counting.
// Assumes tick is a one-cycle pulse per operating clock period on core_clk.
`timescale 1ns/1ps
`include "svm_cfg.svh"

module svm_sampler (
    input  wire logic core_clk, // System clock
    input  wire logic rst,      // Synchronous reset
    svm_smp_if.smp    sp        // Control link
);
    import svm_pkg::*;

    logic [9:0] div_r;
    logic [9:0] div_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [9:0] period;
    logic [3:0] target;
    logic       ev;

    assign period     = `SVM_BASE_PERIOD << (sp.mode - 2'h1);
    assign target     = 4'h1 << sp.sc;
    assign sp.event_p = ev;

    ////////////////////////////////////////////////////////////////////////
    // Next divider and successive counter
    always_comb begin
        div_nxt = div_r;
        cnt_nxt = cnt_r;
        ev      = 1'b0;
        if (!sp.run || sp.init) begin
            div_nxt = 10'h000;
            cnt_nxt = 4'h0;
        end else if (sp.mode == `SVM_MODE_CONT) begin
            // Count select ignored here
            div_nxt = 10'h000;
            cnt_nxt = 4'h0;
            ev      = sp.low;
        end else if (sp.tick) begin
            if (div_r >= period - 10'h001) begin
                div_nxt = 10'h000;
                if (!sp.low) begin
                    cnt_nxt = 4'h0;
                end else if (cnt_r + 4'h1 >= target) begin
                    cnt_nxt = 4'h0;
                    ev      = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 4'h1;
                end
            end else begin
                div_nxt = div_r + 10'h001;
            end
        end
    end

    // Register only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_r <= 10'h000;
            cnt_r <= 4'h0;
        end else begin
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule : svm_sampler

// ---- src/svm_top.sv ----
// Supply voltage monitor control: registers, enable sequence, flag and reset request.
// Assumes an Avalon-MM master on core_clk and an analog comparator outside the clock domain.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "svm_cfg.svh"

// Overview of operation
// - Source select 1 routes external monitor pin, 0 routes core supply.
// - Intermittent event needs 1, 2, 4 or 8 successive lows per count field.
// - Successive count field is ignored in continuous mode.
// - Reset-arm 0xa makes events also issue reset; all events raise flag.
// - Mode 0 continuous; 1, 2, 3 sample every 128, 256, 512 op clocks.
// - Enable 1 starts detection, 0 stops it.
// - Disable resets detector, keeps settings and flag; enable reads 0 afterwards.
// - Changing count, arm or mode while running reinitialises detection.
// - Status bit 8 shows live comparison, 1 when below threshold.
// - Flag bit 0 set by detection; write 1 clears, 0 ignored.
// - Clearing flag while running reinitialises detection.
// - Interrupt enable bit 0 permits or blocks detection interrupts.
// - No interrupt while reset-arm is 0xa.
// - Interrupt request only while flag and enable are both 1.
// - Flag stays set after voltage recovers until software clears it.
// - Reset clears mode, count, interrupt enable; holds flag; releases when status 0.
// - Continuous mode sets flag whenever status is 1 while running.
module svm_top (
    input  wire logic        core_clk,        // System clock, 10 MHz
    input  wire logic        rst,             // Synchronous reset, active high
    input  wire logic [3:0]  avs_address,     // Byte address
    input  wire logic        avs_read,        // Read request
    input  wire logic        avs_write,       // Write request
    input  wire logic [31:0] avs_writedata,   // Write data
    input  wire logic [3:0]  avs_byteenable,  // Byte lanes
    output logic      [31:0] avs_readdata,    // Read data, registered
    output logic             avs_waitrequest, // Stall request
    input  wire logic        op_tick,         // One pulse per operating clock
    input  wire logic        cmp_low_in,      // Comparator result, asynchronous
    output logic             source_select,   // Comparator source select
    output logic      [4:0]  threshold_level, // Comparator threshold code
    output logic             cmp_enable,      // Comparator powered
    output logic             irq_req,         // Interrupt request
    output logic             sys_rst_req      // System reset request
);
    import svm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    svm_smp_if  sp ();
    svm_ctrl_t  ctrl_r;
    svm_ctrl_t  ctrl_nxt;
    svm_state_t st_r;
    svm_state_t st_nxt;
    logic [2:0] stop_r;
    logic [2:0] stop_nxt;
    logic       flag_r;
    logic       flag_nxt;
    logic       ie_r;
    logic       ie_nxt;
    logic       rstq_r;
    logic       rstq_nxt;
    logic       ack_r;
    logic       ack_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic       low_meta_r;
    logic       low_sync_r;
    logic       init;
    logic       req;
    logic       wr_acc;
    logic [15:0] ctl_img;
    logic [15:0] ctl_new;
    logic       armed;
    // Stored-field reset image; bit 3 and enable are not kept
    localparam logic [15:0] ctrl_rst_img = `SVM_CTRL_RST;

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane merge of a 16-bit register image
    // Lanes 2 and 3 are ignored; registers sit in the low half
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [15:0] m;
        m = old;
        if (be[0]) begin
            m[7:0] = wd[7:0];
        end
        if (be[1]) begin
            m[15:8] = wd[15:8];
        end
        return m;
    endfunction : merge16

    // Control image as software sees it, enable from the state
    // Enable reads 1 through the stop countdown too
    function automatic logic [15:0] ctl_pack(input svm_ctrl_t c, input logic en);
        logic [15:0] v;
        v                                   = 16'h0000;
        v[`SVM_CTL_SRC]                     = c.src;
        v[`SVM_CTL_SC_HI:`SVM_CTL_SC_LO]    = c.sc;
        v[`SVM_CTL_LVL_HI:`SVM_CTL_LVL_LO]  = c.lvl;
        v[`SVM_CTL_ARM_HI:`SVM_CTL_ARM_LO]  = c.arm;
        v[`SVM_CTL_MD_HI:`SVM_CTL_MD_LO]    = c.mode;
        v[`SVM_CTL_EN]                      = en;
        return v;
    endfunction : ctl_pack

    ////////////////////////////////////////////////////////////////////////
    // Comparator result synchroniser; only the second stage is used
    // Comparator is not timed to core_clk; two
    // stages keep metastability off the flag logic
    always_ff @(posedge core_clk) begin
        if (rst) begin
            low_meta_r <= 1'b0;
            low_sync_r <= 1'b0;
        end else begin
            low_meta_r <= cmp_low_in;
            low_sync_r <= low_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then the access completes
    // Fixed stall on the first request cycle: each access takes
    // two cycles, traded for registered read data
    // ack_r drops by itself, so requests may run back to back
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_acc          = avs_write & ack_r;
    assign ctl_img         = ctl_pack(ctrl_r, st_r != SVM_ST_OFF);
    assign ctl_new         = merge16(ctl_img, avs_writedata, avs_byteenable);
    assign armed           = (ctrl_r.arm == `SVM_ARM_KEY);

    // Read data prepared in the wait cycle so it stands at the accept edge
    // Status lags the pin by two cycles and wanders
    // while the detector is off
    always_comb begin
        ack_nxt   = req & ~ack_r;
        rdata_nxt = rdata_r;
        if (avs_read && !ack_r) begin
            rdata_nxt = 32'h0000_0000;
            unique case (avs_address)
                `SVM_OFF_CTRL: rdata_nxt[15:0] = ctl_img;
                `SVM_OFF_FLAG: begin
                    rdata_nxt[`SVM_FLG_STATUS] = low_sync_r;
                    rdata_nxt[`SVM_FLG_IRQ]    = flag_r;
                end
                `SVM_OFF_IE:   rdata_nxt[`SVM_IE_BIT] = ie_r;
                default:       rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Control, flag and enable sequence next state
    // Later blocks win: writes, countdown, event, reset forcing;
    // but a flag clear pulses init while running, so no event shares its cycle
    always_comb begin
        ctrl_nxt = ctrl_r;
        st_nxt   = st_r;
        stop_nxt = stop_r;
        flag_nxt = flag_r;
        ie_nxt   = ie_r;
        rstq_nxt = rstq_r;
        init     = 1'b0;

        // Control register write
        // Count field only lands while the stored mode is not 0
        if (wr_acc && avs_address == `SVM_OFF_CTRL) begin
            ctrl_nxt.src  = ctl_new[`SVM_CTL_SRC];
            ctrl_nxt.lvl  = ctl_new[`SVM_CTL_LVL_HI:`SVM_CTL_LVL_LO];
            ctrl_nxt.arm  = ctl_new[`SVM_CTL_ARM_HI:`SVM_CTL_ARM_LO];
            ctrl_nxt.mode = ctl_new[`SVM_CTL_MD_HI:`SVM_CTL_MD_LO];
            if (ctrl_r.mode != `SVM_MODE_CONT) begin
                ctrl_nxt.sc = ctl_new[`SVM_CTL_SC_HI:`SVM_CTL_SC_LO];
            end
            if (st_r == SVM_ST_RUN && (ctrl_nxt.sc != ctrl_r.sc ||
                ctrl_nxt.arm != ctrl_r.arm || ctrl_nxt.mode != ctrl_r.mode)) begin
                init = 1'b1;
            end
            // Enable: a 1 during the stop sequence is not honoured
            // Software polls the bit first; an early 1 would
            // restart the detector without its reset
            if (ctl_new[`SVM_CTL_EN] && st_r == SVM_ST_OFF) begin
                st_nxt = SVM_ST_RUN;
            end else if (!ctl_new[`SVM_CTL_EN] && st_r == SVM_ST_RUN) begin
                st_nxt   = SVM_ST_STOP;
                stop_nxt = `SVM_STOP_CYC;
            end
        end

        // Flag clear by writing 1; 0 ignored
        // Lane 0 only; writing 0 leaves the flag alone
        if (wr_acc && avs_address == `SVM_OFF_FLAG && avs_byteenable[0] &&
            avs_writedata[`SVM_FLG_IRQ]) begin
            flag_nxt = 1'b0;
            if (st_r == SVM_ST_RUN) begin
                init = 1'b1;
            end
        end

        // Interrupt enable write
        // Other bits are not stored and read 0
        if (wr_acc && avs_address == `SVM_OFF_IE && avs_byteenable[0]) begin
            ie_nxt = avs_writedata[`SVM_IE_BIT];
        end

        // Internal reset of the detector, settings and flag untouched
        // Sampler clears as soon as run drops; the count holds
        // the enable readback at 1 and blocks a new enable meanwhile
        if (st_r == SVM_ST_STOP) begin
            if (stop_r == 3'h0) begin
                st_nxt = SVM_ST_OFF;
            end else begin
                stop_nxt = stop_r - 3'h1;
            end
        end

        // Detection event; never in the cycle of a flag clear, which pulses init
        // Flag also marks a reset cause for software
        if (sp.event_p) begin
            flag_nxt = 1'b1;
            if (armed) begin
                rstq_nxt = 1'b1;
            end
        end

        // Reset state forces continuous mode and blocks interrupts
        // Forced every cycle so software cannot re-arm it while
        // the supply is low; release needs clean status, no event
        if (rstq_r) begin
            ctrl_nxt.mode = `SVM_MODE_CONT;
            ctrl_nxt.sc   = 2'h0;
            ie_nxt        = 1'b0;
            if (!low_sync_r && !sp.event_p) begin
                rstq_nxt = 1'b0;
            end
        end
    end

    // Register only
    // Plain registers; all decisions sit in the block above
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r <= svm_ctrl_t'({ctrl_rst_img[15:4], ctrl_rst_img[2:1]});
            st_r   <= SVM_ST_OFF;
            stop_r <= 3'h0;
            flag_r <= `SVM_FLAG_RST;
            ie_r   <= `SVM_IE_RST;
            rstq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            st_r   <= st_nxt;
            stop_r <= stop_nxt;
            flag_r <= flag_nxt;
            ie_r   <= ie_nxt;
            rstq_r <= rstq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sampler link
    // A field write that changes the period also pulses
    // init, so the new period starts from zero
    assign sp.run  = (st_r == SVM_ST_RUN);
    assign sp.init = init;
    assign sp.mode = ctrl_r.mode;
    assign sp.sc   = ctrl_r.sc;
    assign sp.tick = op_tick;
    assign sp.low  = low_sync_r;

    svm_sampler u_smp (
        .core_clk (core_clk),
        .rst      (rst),
        .sp       (sp.smp)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs; a detection under reset-arm never reaches the interrupt line
    // irq_req is a gate of registers; it follows a flag
    // clear or enable write one cycle after the access
    assign source_select   = ctrl_r.src;
    assign threshold_level = ctrl_r.lvl;
    assign cmp_enable      = (st_r == SVM_ST_RUN);
    assign irq_req         = flag_r & ie_r & ~armed;
    assign sys_rst_req     = rstq_r;

endmodule : svm_top

// ---- verif/svm_top_chk.sv ----
// Port checker for the supply monitor control, bound into svm_top.
// Assumes one clock domain and an active-high synchronous reset.
`timescale 1ns/1ps
module svm_top_chk (
    input wire logic        core_clk,        // Clock
    input wire logic        rst,             // Reset
    input wire logic [3:0]  avs_address,     // Address
    input wire logic        avs_read,        // Read
    input wire logic        avs_write,       // Write
    input wire logic [31:0] avs_writedata,   // Write data
    input wire logic [3:0]  avs_byteenable,  // Lanes
    input wire logic [31:0] avs_readdata,    // Read data
    input wire logic        avs_waitrequest, // Stall
    input wire logic        op_tick,         // Op clock
    input wire logic        cmp_low_in,      // Comparator
    input wire logic        source_select,   // Source
    input wire logic [4:0]  threshold_level, // Threshold
    input wire logic        cmp_enable,      // Running
    input wire logic        irq_req,         // Interrupt
    input wire logic        sys_rst_req      // Reset request
);
    logic wr_acc;
    logic rd_acc;
    logic lane0;
    // Accepted bus cycles only; a stalled request changes nothing
    assign wr_acc = avs_write & ~avs_waitrequest;
    assign rd_acc = avs_read & ~avs_waitrequest;
    assign lane0  = avs_byteenable[0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_unmapped_zero: assert property (
        rd_acc && !(avs_address inside {4'h0, 4'h4, 4'h8}) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (
        rd_acc |-> avs_readdata[31:16] == 16'h0) else $error("upper read bits set");
    a_cfg_by_write: assert property (
        !$stable({source_select, threshold_level}) |-> $past(wr_acc))
        else $error("settings moved without a write");
    a_ie_off: assert property (
        wr_acc && lane0 && avs_address == 4'h8 && !avs_writedata[0] |=> !irq_req)
        else $error("interrupt stays after disable");
    a_flag_clear: assert property (
        wr_acc && lane0 && avs_address == 4'h4 && avs_writedata[0] && !cmp_enable
        |=> !irq_req) else $error("interrupt stays after flag clear");
    a_irq_steady: assert property (
        irq_req && !wr_acc |=> irq_req) else $error("interrupt dropped by itself");
    a_rst_no_irq: assert property (
        sys_rst_req |-> !irq_req) else $error("interrupt during reset request");
    a_rst_keeps_en: assert property (
        sys_rst_req |-> cmp_enable) else $error("detector stopped during reset");
    a_rst_release: assert property (
        sys_rst_req ##0 (!cmp_low_in)[*4] |=> !sys_rst_req)
        else $error("reset request held after recovery");
    a_stop_bound: assert property (
        wr_acc && lane0 && avs_address == 4'h0 && !avs_writedata[0]
        |-> ##[1:8] !cmp_enable) else $error("detector did not stop");
endmodule : svm_top_chk

bind svm_top svm_top_chk u_chk (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .op_tick(op_tick), .cmp_low_in(cmp_low_in),
    .source_select(source_select), .threshold_level(threshold_level),
    .cmp_enable(cmp_enable), .irq_req(irq_req), .sys_rst_req(sys_rst_req));

// ---- verif/svm_far_mdl.sv ----
// Far-side model: operating clock source and analog comparator.
// Assumes levels are 5-bit codes on the same scale as the threshold.
`timescale 1ns/1ps
module svm_far_mdl (
    input  wire logic       core_clk,        // Clock
    input  wire logic       rst,             // Reset
    input  wire logic       source_select,   // 1 picks external pin
    input  wire logic [4:0] threshold_level, // Threshold code
    input  wire logic       cmp_enable,      // Comparator powered
    input  wire logic [4:0] vdd_lvl,         // Core supply level
    input  wire logic [4:0] ext_lvl,         // External pin level
    output logic            op_tick,         // Op clock pulse
    output logic            cmp_low_in       // Below threshold
);
    logic [4:0] volt;
    logic       wander_r;
    // Op clock is every second core cycle to keep long counts short
    always_ff @(posedge core_clk) begin
        op_tick  <= rst ? 1'b0 : ~op_tick;
        wander_r <= rst ? 1'b0 : ~wander_r;
    end
    assign volt = source_select ? ext_lvl : vdd_lvl;
    // An unpowered comparator has no defined answer, so it wanders
    assign cmp_low_in = cmp_enable ? (volt < threshold_level) : wander_r;
endmodule : svm_far_mdl

// ---- verif/tb.sv ----
// Self-checking bench for the supply monitor control.
// Assumes svm_top, svm_far_mdl and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "svm_cfg.svh"
module tb;
    logic        core_clk, rst, avs_read, avs_write, avs_waitrequest, op_tick;
    logic        cmp_low_in, source_select, cmp_enable, irq_req, sys_rst_req;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q, seed;
    logic [4:0]  threshold_level, vdd_lvl, ext_lvl;
    logic [15:0] e_ctrl, d;
    int          fail_count, compares, i, m, s, n;

    svm_top DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .op_tick(op_tick), .cmp_low_in(cmp_low_in),
        .source_select(source_select), .threshold_level(threshold_level),
        .cmp_enable(cmp_enable), .irq_req(irq_req), .sys_rst_req(sys_rst_req));
    svm_far_mdl far (.core_clk(core_clk), .rst(rst), .source_select(source_select),
        .threshold_level(threshold_level), .cmp_enable(cmp_enable), .vdd_lvl(vdd_lvl),
        .ext_lvl(ext_lvl), .op_tick(op_tick), .cmp_low_in(cmp_low_in));
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic chk_val(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk_val
    // Cycle counts allow a few cycles for sync and tick phase
    task automatic chk_cnt(input int exp, input int got);
        compares++;
        if (got < exp - 8 || got > exp + 8) begin
            fail_count++;
            $display("unexpected at %0t: %0d cycles, want %0d", $time, got, exp);
        end
    endtask : chk_cnt
    // One bus cycle; held until the stall drops, then released
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] dd);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= {16'h0000, dd};
        avs_read      <= ~wr;
        avs_write     <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 16'h0000);
        chk_val(exp, q);
    endtask : rd
    // Count field only lands while the stored mode is intermittent
    task automatic wctl(input logic [15:0] dd);
        bus(1'b1, `SVM_OFF_CTRL, dd);
        e_ctrl = {dd[15], (e_ctrl[2:1] == 2'h0) ? e_ctrl[14:13] : dd[14:13], dd[12:4],
                  1'b0, dd[2:0]};
    endtask : wctl
    task automatic wait_en(input logic v);
        n = 0;
        do begin
            bus(1'b0, `SVM_OFF_CTRL, 16'h0000);
            n++;
        end while (q[0] !== v && n < 20);
        chk_val(v, q[0]);
    endtask : wait_en
    task automatic settle(input int k);
        repeat (k) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle
    task automatic results;
        $display("compares %0d, fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Watchdog well beyond the expected run of some 6000 cycles
    initial begin
        #2000000;
        fail_count++;
        results;
    end
    initial begin
        rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
        avs_writedata = 32'h0; avs_byteenable = 4'h3; vdd_lvl = 5'h1f; ext_lvl = 5'h1f;
        seed = 32'hff68382f; e_ctrl = 16'h0; fail_count = 0; compares = 0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd(`SVM_OFF_CTRL, 32'h0);
        bus(1'b0, `SVM_OFF_FLAG, 16'h0);
        chk_val(32'h0, q & 32'hfffffeff);
        rd(`SVM_OFF_IE, 32'h0);
        rd(4'hc, 32'h0);
        // Random settings with the detector off; threshold kept legal
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wctl({seed[15:13], 5'h0c + seed[12:8] % 5'd20, seed[7:1], 1'b0});
            rd(`SVM_OFF_CTRL, {16'h0, e_ctrl});
            bus(1'b1, `SVM_OFF_IE, seed[31:16]);
            rd(`SVM_OFF_IE, {31'h0, seed[16]});
        end
        $display("test registers done");
        ext_lvl <= 5'h00;
        wctl(16'h1001);
        wait_en(1'b1);
        bus(1'b1, `SVM_OFF_FLAG, 16'h0001);
        bus(1'b1, `SVM_OFF_IE, 16'h0001);
        settle(6);
        rd(`SVM_OFF_FLAG, 32'h0);
        chk_val(0, irq_req);
        wctl(16'h9001);
        settle(6);
        rd(`SVM_OFF_FLAG, 32'h101);
        chk_val(1, irq_req);
        ext_lvl <= 5'h1f;
        settle(6);
        rd(`SVM_OFF_FLAG, 32'h001);
        bus(1'b1, `SVM_OFF_IE, 16'h0000);
        settle(1);
        chk_val(0, irq_req);
        wctl(16'h9000);
        rd(`SVM_OFF_CTRL, {16'h0, e_ctrl | 16'h0001});
        wait_en(1'b0);
        rd(`SVM_OFF_CTRL, {16'h0, e_ctrl});
        bus(1'b1, `SVM_OFF_FLAG, 16'h0000);
        bus(1'b0, `SVM_OFF_FLAG, 16'h0000);
        chk_val(1, q[0]);
        $display("test continuous done");
        // Modes 1 to 3, every count in mode 1; tick every 2 cycles, supply held low
        ext_lvl <= 5'h00;
        bus(1'b1, `SVM_OFF_FLAG, 16'h0001);
        bus(1'b1, `SVM_OFF_IE, 16'h0001);
        for (i = 0; i < 6; i++) begin
            m = (i < 4) ? 1 : i - 2;
            s = (i < 4) ? i : 0;
            d = {1'b1, s[1:0], 5'h10, 4'h0, 1'b0, m[1:0], 1'b1};
            wctl(d);
            wait_en(1'b1);
            wctl(d);
            bus(1'b1, `SVM_OFF_FLAG, 16'h0001);
            settle(1);
            n = 0;
            while (irq_req !== 1'b1 && n < 9000) begin
                @(posedge core_clk);
                n++;
            end
            chk_cnt((128 << (m - 1)) * (1 << s) * 2, n);
            chk_val(0, sys_rst_req);
        end
        $display("test intermittent done");
        wctl(16'h90a3);
        bus(1'b1, `SVM_OFF_FLAG, 16'h0001);
        settle(1);
        n = 0;
        while (sys_rst_req !== 1'b1 && n < 9000) begin
            @(posedge core_clk);
            n++;
        end
        chk_cnt(256, n);
        settle(2);
        chk_val(0, irq_req);
        rd(`SVM_OFF_CTRL, 32'h90a1);
        rd(`SVM_OFF_IE, 32'h0);
        rd(`SVM_OFF_FLAG, 32'h101);
        ext_lvl <= 5'h1f;
        settle(8);
        chk_val(0, sys_rst_req);
        $display("test reset arm done");
        results;
    end
endmodule : tb
